// ---- design/occ_pkg.sv ----
// Package: register map, field layout and modes of the output compare block
package occ_pkg;
   // Register offsets, indices on the register port
   localparam logic [7:0] ADDR_STATUS     = 8'h00;
   localparam logic [7:0] ADDR_MASK       = 8'h01;
   localparam logic [7:0] ADDR_TIMER_CTRL = 8'h02;
   localparam logic [7:0] ADDR_PERIOD_A   = 8'h03;
   localparam logic [7:0] ADDR_PERIOD_B   = 8'h04;
   localparam logic [7:0] ADDR_COUNT_A    = 8'h05;
   localparam logic [7:0] ADDR_COUNT_B    = 8'h06;
   localparam logic [7:0] ADDR_PIN_STATE  = 8'h07;
   localparam logic [7:0] ADDR_CHAN_BASE  = 8'h10;
   localparam int         CHAN_STRIDE     = 4;
   localparam logic [1:0] CH_SECONDARY    = 2'h0;
   localparam logic [1:0] CH_PRIMARY      = 2'h1;
   localparam logic [1:0] CH_CONTROL      = 2'h2;
   // Field positions
   localparam int         MODE_LSB        = 0;
   localparam int         MODE_MSB        = 2;
   localparam int         BASE_SEL_BIT    = 3;
   localparam int         RUN_A_BIT       = 15;
   localparam int         RUN_B_BIT       = 14;
   // Reset values
   localparam logic [15:0] RESET_WORD     = 16'h0000;
   localparam logic [15:0] RESET_PERIOD   = 16'hffff;
   // Compare modes
   typedef enum logic [2:0] {
      MODE_OFF    = 3'h0,
      MODE_LOW    = 3'h1,
      MODE_HIGH   = 3'h2,
      MODE_TOGGLE = 3'h3,
      MODE_SINGLE = 3'h4,
      MODE_CONT   = 3'h5
   } occ_mode_type;
endpackage : occ_pkg

// ---- design/occ_chan_if.sv ----
// Interface: configuration and status between the top and one compare channel
`timescale 1ns/1ps
interface occ_chan_if;
   logic [2:0]  mode;
   logic        base_sel;
   logic [15:0] primary;
   logic [15:0] secondary;
   logic        arm;
   logic        pin;
   logic        match;
   modport top  (output mode, base_sel, primary, secondary, arm, input pin, match);
   modport chan (input mode, base_sel, primary, secondary, arm, output pin, match);
endinterface : occ_chan_if

// ---- design/occ_channel.sv ----
// One compare channel: compare against the selected time base and drive the pin
`timescale 1ns/1ps
module occ_channel
   import occ_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [15:0] count_a,
   input  wire logic [15:0] count_b,
   input  wire logic        tick_a,
   input  wire logic        tick_b,
   occ_chan_if.chan         cif
);
   logic [15:0] count;
   logic        tick;
   logic        hit_primary;
   logic        hit_secondary;
   logic        done;

   // Pick the time base and its advance pulse
   assign count = cif.base_sel ? count_b : count_a;
   assign tick  = cif.base_sel ? tick_b : tick_a;
   // Match only on a live advance so a stopped timer does not repeat actions
   assign hit_primary   = tick && (count == cif.primary);
   assign hit_secondary = tick && (count == cif.secondary);
   assign cif.match     = (hit_primary || hit_secondary) && (cif.mode != MODE_OFF);

   // One-shot done flag, cleared by a fresh write of the single mode
   always_ff @(posedge clk)
   begin
      if (!rstn || cif.arm)
         done <= 1'b0;
      else if (cif.mode == MODE_SINGLE && hit_secondary)
         done <= 1'b1;
   end

   // Pin action; a wrap before reaching the value simply leaves the pin alone
   always_ff @(posedge clk)
   begin
      if (!rstn)
         cif.pin <= 1'b0;
      else
      begin
         case (occ_mode_type'(cif.mode))
            MODE_LOW:    if (hit_primary) cif.pin <= 1'b0;
            MODE_HIGH:   if (hit_primary) cif.pin <= 1'b1;
            MODE_TOGGLE: if (hit_primary) cif.pin <= ~cif.pin;
            MODE_SINGLE:
            begin
               if (hit_secondary)
                  cif.pin <= 1'b0;
               else if (hit_primary && !done)
                  cif.pin <= 1'b1;
            end
            MODE_CONT:
            begin
               if (hit_secondary)
                  cif.pin <= 1'b0;
               else if (hit_primary)
                  cif.pin <= 1'b1;
            end
            default: cif.pin <= cif.pin;
         endcase
      end
   end
endmodule : occ_channel

// ---- design/occ_top.sv ----
// Output compare block: register port, two time bases, compare channels, interrupt
`timescale 1ns/1ps
module occ_top
   import occ_pkg::*;
#(
   parameter int CHANNELS = 8
)
(
   input  wire logic                clk,
   input  wire logic                rstn,
   input  wire logic [7:0]          addr,
   input  wire logic [15:0]         wdata,
   input  wire logic                wr,
   input  wire logic                rd,
   output logic [15:0]              rdata,
   output logic [CHANNELS-1:0]      compare_output_pin,
   output logic                     irq
);
   logic [15:0]         timer_control_register;
   logic [15:0]         period_a;
   logic [15:0]         period_b;
   logic [15:0]         count_a;
   logic [15:0]         count_b;
   logic                tick_a;
   logic                tick_b;
   logic [15:0]         status;
   logic [15:0]         mask;
   logic [15:0]         next_rdata;
   logic [15:0]         primary_compare_value   [CHANNELS];
   logic [15:0]         secondary_compare_value [CHANNELS];
   logic [15:0]         compare_control_register[CHANNELS];
   logic [CHANNELS-1:0] arm;
   logic [CHANNELS-1:0] match;
   logic                chan_hit;
   logic [2:0]          chan_idx;
   logic [1:0]          chan_reg;

   // Channel window decode: four words per channel from the base
   assign chan_hit = (addr >= ADDR_CHAN_BASE)
                  && (addr < 8'(ADDR_CHAN_BASE + CHANNELS * CHAN_STRIDE));
   assign chan_idx = 3'((addr - ADDR_CHAN_BASE) >> 2);
   assign chan_reg = addr[1:0];

   // Timer control: run bits for both time bases
   always_ff @(posedge clk)
   begin
      if (!rstn)
         timer_control_register <= RESET_WORD;
      else if (wr && addr == ADDR_TIMER_CTRL)
         timer_control_register <= wdata;
   end

   // Period registers
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         period_a <= RESET_PERIOD;
         period_b <= RESET_PERIOD;
      end
      else if (wr && addr == ADDR_PERIOD_A)
         period_a <= wdata;
      else if (wr && addr == ADDR_PERIOD_B)
         period_b <= wdata;
   end

   // Time bases advance once per clock while running, wrap at the period
   assign tick_a = timer_control_register[RUN_A_BIT];
   assign tick_b = timer_control_register[RUN_B_BIT];
   always_ff @(posedge clk)
   begin
      if (!rstn)
         count_a <= RESET_WORD;
      else if (wr && addr == ADDR_COUNT_A)
         count_a <= wdata;
      else if (tick_a)
         count_a <= (count_a >= period_a) ? RESET_WORD : count_a + 16'h0001;
   end
   always_ff @(posedge clk)
   begin
      if (!rstn)
         count_b <= RESET_WORD;
      else if (wr && addr == ADDR_COUNT_B)
         count_b <= wdata;
      else if (tick_b)
         count_b <= (count_b >= period_b) ? RESET_WORD : count_b + 16'h0001;
   end

   // Per-channel compare values and control words
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < CHANNELS; i++)
         begin
            primary_compare_value[i]    <= RESET_WORD;
            secondary_compare_value[i]  <= RESET_WORD;
            compare_control_register[i] <= RESET_WORD;
         end
      end
      else if (wr && chan_hit)
      begin
         case (chan_reg)
            CH_SECONDARY: secondary_compare_value[chan_idx]  <= wdata;
            CH_PRIMARY:   primary_compare_value[chan_idx]    <= wdata;
            CH_CONTROL:   compare_control_register[chan_idx] <= wdata;
            default:      ;
         endcase
      end
   end

   // A control write that sets single mode re-arms that channel
   always_comb
   begin
      arm = '0;
      if (wr && chan_hit && chan_reg == CH_CONTROL
          && wdata[MODE_MSB:MODE_LSB] == MODE_SINGLE)
         arm[chan_idx] = 1'b1;
   end

   // Channels, each with its own interface
   for (genvar g = 0; g < CHANNELS; g++)
   begin : gen_chan
      occ_chan_if cif ();
      assign cif.mode      = compare_control_register[g][MODE_MSB:MODE_LSB];
      assign cif.base_sel  = compare_control_register[g][BASE_SEL_BIT];
      assign cif.primary   = primary_compare_value[g];
      assign cif.secondary = secondary_compare_value[g];
      assign cif.arm       = arm[g];
      assign compare_output_pin[g] = cif.pin;
      assign match[g]      = cif.match;
      occ_channel u_chan (
         .clk     (clk),
         .rstn    (rstn),
         .count_a (count_a),
         .count_b (count_b),
         .tick_a  (tick_a),
         .tick_b  (tick_b),
         .cif     (cif.chan)
      );
   end

   // Sticky match flags; a new match wins over a write-one clear
   always_ff @(posedge clk)
   begin
      if (!rstn)
         status <= RESET_WORD;
      else
         status <= (status & ~((wr && addr == ADDR_STATUS) ? wdata : 16'h0000))
                 | 16'(match);
   end

   // Interrupt mask
   always_ff @(posedge clk)
   begin
      if (!rstn)
         mask <= RESET_WORD;
      else if (wr && addr == ADDR_MASK)
         mask <= wdata;
   end

   assign irq = |(status & mask);

   // Read mux; unmapped addresses read zero
   always_comb
   begin
      next_rdata = 16'h0000;
      if (chan_hit)
      begin
         case (chan_reg)
            CH_SECONDARY: next_rdata = secondary_compare_value[chan_idx];
            CH_PRIMARY:   next_rdata = primary_compare_value[chan_idx];
            CH_CONTROL:   next_rdata = compare_control_register[chan_idx];
            default:      next_rdata = 16'h0000;
         endcase
      end
      else
      begin
         case (addr)
            ADDR_STATUS:     next_rdata = status;
            ADDR_MASK:       next_rdata = mask;
            ADDR_TIMER_CTRL: next_rdata = timer_control_register;
            ADDR_PERIOD_A:   next_rdata = period_a;
            ADDR_PERIOD_B:   next_rdata = period_b;
            ADDR_COUNT_A:    next_rdata = count_a;
            ADDR_COUNT_B:    next_rdata = count_b;
            ADDR_PIN_STATE:  next_rdata = 16'(compare_output_pin);
            default:         next_rdata = 16'h0000;
         endcase
      end
   end

   // Read data stand one cycle after the strobe
   always_ff @(posedge clk)
   begin
      if (!rstn)
         rdata <= RESET_WORD;
      else if (rd)
         rdata <= next_rdata;
      else
         rdata <= RESET_WORD;
   end
endmodule : occ_top

// ---- test/occ_checker.sv ----
// Checker: port-level properties of the compare block
`timescale 1ns/1ps
module occ_checker
   import occ_pkg::*;
#(parameter int CHANNELS = 8)
(
   input wire logic                clk,
   input wire logic                rstn,
   input wire logic [7:0]          addr,
   input wire logic [15:0]         wdata,
   input wire logic                wr,
   input wire logic                rd,
   input wire logic [15:0]         rdata,
   input wire logic [CHANNELS-1:0] compare_output_pin,
   input wire logic                irq
);
   logic [CHANNELS-1:0] msk;
   logic [1:0]          run;
   // Shadow of mask and run bits; pins may only move while a base runs
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         msk <= '0;
         run <= 2'h0;
      end
      else if (wr && addr == ADDR_MASK)
         msk <= wdata[CHANNELS-1:0];
      else if (wr && addr == ADDR_TIMER_CTRL)
         run <= {wdata[RUN_B_BIT], wdata[RUN_A_BIT]};
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence read_of(logic [7:0] a);
      rd && addr == a ##1 1'b1;
   endsequence
   reset_clear_a: assert property ($rose(rstn) |-> compare_output_pin == '0 && !irq)
      else $error("pins or irq set after reset");
   rdata_idle_a: assert property (!rd |=> rdata == 16'h0000)
      else $error("rdata set without read");
   unmapped_read_a: assert property (read_of(8'h08) |-> rdata == 16'h0000)
      else $error("unmapped read not zero");
   mask_readback_a: assert property (read_of(ADDR_MASK) |-> rdata[CHANNELS-1:0] == $past(msk))
      else $error("mask readback wrong");
   pin_readback_a: assert property (read_of(ADDR_PIN_STATE) |->
      rdata[CHANNELS-1:0] == $past(compare_output_pin)) else $error("pin readback wrong");
   mask_gate_a: assert property (msk == '0 |-> !irq)
      else $error("irq while all masked");
   pin_event_a: assert property (((compare_output_pin ^ $past(compare_output_pin)) & msk) != '0 |-> irq)
      else $error("pin action without irq");
   stopped_hold_a: assert property (run == 2'h0 |=> $stable(compare_output_pin))
      else $error("pin moved with bases stopped");
endmodule : occ_checker

bind occ_top occ_checker #(.CHANNELS(CHANNELS)) occ_checker_inst (.clk(clk), .rstn(rstn),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
   .compare_output_pin(compare_output_pin), .irq(irq));

// ---- test/occ_pin_monitor.sv ----
// Partner: load on the pins, counting rising edges
`timescale 1ns/1ps
module occ_pin_monitor
(
   input wire logic       clk,
   input wire logic       rstn,
   input wire logic [7:0] pins,
   output int             rises [8]
);
   logic [7:0] last;
   // Edges as a capture input on the far side sees them
   always_ff @(posedge clk)
   begin
      last <= pins;
      for (int i = 0; i < 8; i++)
         rises[i] <= !rstn ? 0 : rises[i] + int'(pins[i] && !last[i]);
   end
endmodule : occ_pin_monitor

// ---- test/occ_top_tb.sv ----
// Testbench: register driver and cycle model of the compare block
`timescale 1ns/1ps
module occ_top_tb
   import occ_pkg::*;
;
   logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, irq;
   logic [7:0]  addr = 8'h00, pin, mp, sel, arm, base;
   logic [15:0] wdata = 16'h0000, rdata, a, b, p, cnt [2], per [2], pri [8], sec [8];
   logic [2:0]  mode [8], md [8] = '{MODE_LOW, MODE_HIGH, MODE_TOGGLE, MODE_SINGLE,
                                     MODE_CONT, MODE_HIGH, MODE_SINGLE, MODE_CONT};
   logic [1:0]  run;
   int          rises [8], mr [8], err_count = 0, total_checks = 0, seed = 54, cyc = 0;

   occ_top #(.CHANNELS(8)) occ_top_inst (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .compare_output_pin(pin), .irq(irq));
   occ_pin_monitor occ_pin_monitor_inst (.clk(clk), .rstn(rstn), .pins(pin), .rises(rises));

   initial
      forever #12.5 clk = ~clk;

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic final_report;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report

   task automatic wr_reg(input logic [7:0] ad, input logic [15:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= ad;
      wdata <= d;
   endtask : wr_reg

   // Quiet bus, then settle to mid-cycle
   task automatic idle(input int n);
      @(posedge clk);
      wr <= 1'b0;
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : idle

   task automatic rd_chk(input logic [7:0] ad, input logic [15:0] e);
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      addr <= ad;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check(rdata, e);
   endtask : rd_chk

   // Model: act on this cycle's count, advance bases, then take the write
   always @(posedge clk)
   begin
      int c;
      logic hp, hs, go, old;
      c = int'(addr >> 2) - 4;
      if (!rstn)
      begin
         {run, mp, sel, arm} = '0;
         per = '{16'hffff, 16'hffff};
         cnt = '{16'h0000, 16'h0000};
         for (int i = 0; i < 8; i++)
            {mode[i], pri[i], sec[i], mr[i]} = '0;
      end
      else
      begin
         for (int i = 0; i < 8; i++)
         begin
            hp = run[sel[i]] && cnt[sel[i]] == pri[i];
            hs = run[sel[i]] && cnt[sel[i]] == sec[i];
            go = arm[i] || mode[i] == MODE_CONT;
            old = mp[i];
            case (mode[i])
               MODE_LOW:    mp[i] = mp[i] & !hp;
               MODE_HIGH:   mp[i] = mp[i] | hp;
               MODE_TOGGLE: mp[i] = mp[i] ^ hp;
               MODE_SINGLE, MODE_CONT:
                  if (go && hs)
                     {mp[i], arm[i]} = 2'h0;
                  else if (go && hp)
                     mp[i] = 1'b1;
               default: ;
            endcase
            mr[i] += int'(mp[i] && !old);
         end
         for (int t = 0; t < 2; t++)
            if (run[t])
               cnt[t] = (cnt[t] == per[t]) ? 16'h0000 : cnt[t] + 16'h0001;
         if (wr)
            case (addr)
               ADDR_TIMER_CTRL: run = {wdata[RUN_B_BIT], wdata[RUN_A_BIT]};
               ADDR_PERIOD_A:   per[0] = wdata;
               ADDR_PERIOD_B:   per[1] = wdata;
               ADDR_COUNT_A:    cnt[0] = wdata;
               ADDR_COUNT_B:    cnt[1] = wdata;
               default:
                  if (addr >= ADDR_CHAN_BASE && c < 8)
                     case (addr[1:0])
                        CH_SECONDARY: sec[c] = wdata;
                        CH_PRIMARY:   pri[c] = wdata;
                        CH_CONTROL:   {arm[c], sel[c], mode[c]} = {wdata[2:0] == MODE_SINGLE, wdata[3:0]};
                        default: ;
                     endcase
            endcase
      end
   end

   // Pins against the model every cycle; hang guard
   always @(negedge clk)
   begin
      check({8'h00, pin}, {8'h00, mp});
      cyc++;
      if (cyc == 3000)
      begin
         err_count++;
         final_report();
      end
   end

   initial
   begin
      repeat (20) @(posedge clk);
      rstn <= 1'b1;
      rd_chk(ADDR_PERIOD_B, RESET_PERIOD);
      rd_chk(ADDR_MASK, RESET_WORD);
      rd_chk(8'h08, 16'h0000);
      rd_chk(ADDR_CHAN_BASE + CH_CONTROL, RESET_WORD);
      // Interrupt: raise, mask, clear
      wr_reg(ADDR_MASK, 16'h0001);
      wr_reg(ADDR_PERIOD_A, 16'h0014);
      wr_reg(ADDR_CHAN_BASE + CH_PRIMARY, 16'h0005);
      wr_reg(ADDR_CHAN_BASE + CH_CONTROL, 16'h0002);
      wr_reg(ADDR_TIMER_CTRL, 16'h8000);
      idle(10);
      check({15'h0000, irq}, 16'h0001);
      rd_chk(ADDR_STATUS, 16'h0001);
      wr_reg(ADDR_MASK, 16'h0000);
      idle(1);
      check({15'h0000, irq}, 16'h0000);
      wr_reg(ADDR_MASK, 16'h0001);
      wr_reg(ADDR_TIMER_CTRL, 16'h0000);
      wr_reg(ADDR_STATUS, 16'h0001);
      idle(1);
      check({15'h0000, irq}, 16'h0000);
      rd_chk(ADDR_STATUS, 16'h0000);
      // Two rounds, every mode but off; the second re-arms the single pulses
      for (int r = 0; r < 2; r++)
      begin
         wr_reg(ADDR_TIMER_CTRL, 16'h0000);
         wr_reg(ADDR_COUNT_A, 16'h0000);
         wr_reg(ADDR_COUNT_B, 16'h0000);
         wr_reg(ADDR_PERIOD_A, 16'h0028);
         wr_reg(ADDR_PERIOD_B, 16'h0039);
         for (int i = 0; i < 8; i++)
         begin
            base = ADDR_CHAN_BASE + 8'(4 * i);
            p = ($random(seed) & 1) ? 16'h0039 : 16'h0028;
            a = 16'($unsigned($random(seed)) % (p - 1));
            b = a + 16'h0001 + 16'($unsigned($random(seed)) % (p - a));
            wr_reg(base + CH_PRIMARY, (i == 5) ? 16'h0100 : a);
            wr_reg(base + CH_SECONDARY, b);
            wr_reg(base + CH_CONTROL, {12'h000, p[0], md[i]});
         end
         wr_reg(ADDR_TIMER_CTRL, 16'hc000);
         idle(300);
      end
      wr_reg(ADDR_TIMER_CTRL, 16'h0000);
      idle(1);
      rd_chk(ADDR_PIN_STATE, {8'h00, mp});
      rd_chk(ADDR_COUNT_B, cnt[1]);
      for (int i = 0; i < 8; i++)
         check(16'(rises[i]), 16'(mr[i]));
      final_report();
   end
endmodule : occ_top_tb
